// >>> hdl/cpu_register_set.sv
// core register set with stack select, fast interrupt save/restore and float flags
// assumes the core drives one-cycle strobes synchronous to core_clk_in
//
// Notes on behaviour
// - sixteen 32-bit general registers, any usable as data or address.
// - general register zero is the stack pointer used by stack operations.
// - status word stack select bit picks interrupt or user stack pointer copy.
// - exception base register holds exception vector table start address.
// - interrupt base register holds interrupt vector table start address.
// - program counter holds address of instruction currently executing.
// - fast interrupt accept copies program counter into saved counter.
// - fast interrupt accept copies status word into same-layout saved status.
// - fast interrupt accept branches program counter to fast vector register.
// - enabled float exception sets its matching cause flag.
// - sticky flags stay set, even masked, until software clears them.
// - ten control registers besides the general registers.
//
// Chosen here: the register addresses and the strobed register port.

`timescale 1ns/1ps

module cpu_register_set #(
  parameter int unsigned DW = cpu_regs_pkg::DATA_W
) (
  // clock and reset
  input  wire logic                              core_clk_in,
  input  wire logic                              rst_n_in,
  // register port
  input  wire logic [cpu_regs_pkg::ADDR_W-1:0]   reg_addr_in,
  input  wire logic [DW-1:0]                     reg_wdata_in,
  input  wire logic                              reg_wr_in,
  input  wire logic                              reg_rd_in,
  output logic      [DW-1:0]                     reg_rdata_out,
  // execution events
  input  wire logic                              pc_load_in,
  input  wire logic [DW-1:0]                     pc_next_in,
  input  wire logic                              fast_irq_accept_in,
  input  wire logic                              fast_irq_return_in,
  input  wire logic                              sp_update_in,
  input  wire logic [DW-1:0]                     sp_next_in,
  input  wire logic [cpu_regs_pkg::FP_EXC_NUM-1:0] fp_exc_in,
  // state views
  output logic      [DW-1:0]                     stack_pointer_out,
  output logic      [DW-1:0]                     program_counter_out,
  output logic      [DW-1:0]                     status_word_out,
  output logic      [DW-1:0]                     exception_base_out,
  output logic      [DW-1:0]                     interrupt_base_out
);
  import cpu_regs_pkg::*;

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [DW-1:0] gpr_r [GPR_NUM];
  logic [DW-1:0] interrupt_stack_pointer_r;
  logic [DW-1:0] user_stack_pointer_r;
  logic [DW-1:0] exception_base_r;
  logic [DW-1:0] interrupt_base_r;
  logic [DW-1:0] program_counter_r;
  logic [DW-1:0] status_word_r;
  logic [DW-1:0] saved_counter_r;
  logic [DW-1:0] saved_status_word_r;
  logic [DW-1:0] fast_vector_r;
  logic [DW-1:0] float_status_word_r;

  logic          wr_gpr;
  logic          user_sel;
  logic [DW-1:0] active_sp;
  logic [DW-1:0] sp_nxt;
  logic          sp_wr;
  logic [FP_EXC_NUM-1:0] exception_enable_bits;
  logic [FP_EXC_NUM-1:0] cause_flags_nxt;
  logic [FP_EXC_NUM-1:0] sticky_flags_nxt;
  logic [FP_EXC_NUM-1:0] sticky_wr;

  assign wr_gpr   = reg_wr_in && (reg_addr_in <= IDX_GPR_LAST);
  assign user_sel = status_word_r[STATUS_STACK_SEL_BIT];
  assign active_sp = user_sel ? user_stack_pointer_r : interrupt_stack_pointer_r;

  // ---------------------------------------------------------------
  // stack pointer: register zero mirrors the selected copy
  // ---------------------------------------------------------------
  // a stack update from the core beats a software write in the same cycle
  always_comb begin
    sp_wr  = 1'b0;
    sp_nxt = active_sp;
    if (sp_update_in) begin
      sp_wr  = 1'b1;
      sp_nxt = sp_next_in;
    end else if (reg_wr_in && reg_addr_in == 5'h00) begin
      sp_wr  = 1'b1;
      sp_nxt = reg_wdata_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      interrupt_stack_pointer_r <= RST_ZERO;
      user_stack_pointer_r      <= RST_ZERO;
    end else begin
      if (sp_wr && !user_sel) begin
        interrupt_stack_pointer_r <= sp_nxt;
      end else if (reg_wr_in && reg_addr_in == IDX_INT_SP) begin
        interrupt_stack_pointer_r <= reg_wdata_in;
      end
      if (sp_wr && user_sel) begin
        user_stack_pointer_r <= sp_nxt;
      end else if (reg_wr_in && reg_addr_in == IDX_USER_SP) begin
        user_stack_pointer_r <= reg_wdata_in;
      end
    end
  end

  // ---------------------------------------------------------------
  // general registers 1..15
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < GPR_NUM; i++) begin
        gpr_r[i] <= RST_ZERO;
      end
    end else if (wr_gpr && reg_addr_in != 5'h00) begin
      gpr_r[reg_addr_in[3:0]] <= reg_wdata_in;
    end
  end

  // ---------------------------------------------------------------
  // table bases and fast vector
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      exception_base_r <= RST_ZERO;
      interrupt_base_r <= RST_ZERO;
      fast_vector_r    <= RST_ZERO;
    end else if (reg_wr_in) begin
      if (reg_addr_in == IDX_EXC_BASE) begin
        exception_base_r <= reg_wdata_in;
      end
      if (reg_addr_in == IDX_INT_BASE) begin
        interrupt_base_r <= reg_wdata_in;
      end
      if (reg_addr_in == IDX_FAST_VEC) begin
        fast_vector_r <= reg_wdata_in;
      end
    end
  end

  // ---------------------------------------------------------------
  // program counter, status word and their backups
  // ---------------------------------------------------------------
  // fast interrupt accept outranks return, then normal flow, then software
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      program_counter_r <= RST_ZERO;
      status_word_r     <= RST_ZERO;
    end else if (fast_irq_accept_in) begin
      program_counter_r <= fast_vector_r;
    end else if (fast_irq_return_in) begin
      program_counter_r <= saved_counter_r;
      status_word_r     <= saved_status_word_r;
    end else begin
      if (pc_load_in) begin
        program_counter_r <= pc_next_in;
      end else if (reg_wr_in && reg_addr_in == IDX_PROG_CNT) begin
        program_counter_r <= reg_wdata_in;
      end
      if (reg_wr_in && reg_addr_in == IDX_STATUS) begin
        status_word_r <= reg_wdata_in;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      saved_counter_r     <= RST_ZERO;
      saved_status_word_r <= RST_ZERO;
    end else if (fast_irq_accept_in) begin
      saved_counter_r     <= program_counter_r;
      saved_status_word_r <= status_word_r;
    end else if (reg_wr_in) begin
      if (reg_addr_in == IDX_SAVED_CNT) begin
        saved_counter_r <= reg_wdata_in;
      end
      if (reg_addr_in == IDX_SAVED_STATUS) begin
        saved_status_word_r <= reg_wdata_in;
      end
    end
  end

  // ---------------------------------------------------------------
  // float status word
  // ---------------------------------------------------------------
  assign exception_enable_bits = float_status_word_r[FP_EN_LSB +: FP_EXC_NUM];
  assign sticky_wr = {FP_EXC_NUM{reg_wr_in && reg_addr_in == IDX_FLOAT_STATUS}};

  // cause flags show only the latest operation; sticky set wins over a clear
  always_comb begin
    cause_flags_nxt  = float_status_word_r[FP_CAUSE_LSB +: FP_EXC_NUM];
    sticky_flags_nxt = float_status_word_r[FP_STICKY_LSB +: FP_EXC_NUM];
    if (|sticky_wr) begin
      cause_flags_nxt  = reg_wdata_in[FP_CAUSE_LSB +: FP_EXC_NUM];
      sticky_flags_nxt = reg_wdata_in[FP_STICKY_LSB +: FP_EXC_NUM];
    end
    if (|fp_exc_in) begin
      cause_flags_nxt = fp_exc_in & exception_enable_bits;
    end
    sticky_flags_nxt = sticky_flags_nxt | fp_exc_in;
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      float_status_word_r <= RST_FP_STATUS;
    end else begin
      if (|sticky_wr) begin
        float_status_word_r <= reg_wdata_in;
      end
      float_status_word_r[FP_CAUSE_LSB +: FP_EXC_NUM]  <= cause_flags_nxt;
      float_status_word_r[FP_STICKY_LSB +: FP_EXC_NUM] <= sticky_flags_nxt;
    end
  end

  // ---------------------------------------------------------------
  // read port and state views
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= RST_ZERO;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        IDX_INT_SP:       reg_rdata_out <= interrupt_stack_pointer_r;
        IDX_USER_SP:      reg_rdata_out <= user_stack_pointer_r;
        IDX_EXC_BASE:     reg_rdata_out <= exception_base_r;
        IDX_INT_BASE:     reg_rdata_out <= interrupt_base_r;
        IDX_PROG_CNT:     reg_rdata_out <= program_counter_r;
        IDX_STATUS:       reg_rdata_out <= status_word_r;
        IDX_SAVED_CNT:    reg_rdata_out <= saved_counter_r;
        IDX_SAVED_STATUS: reg_rdata_out <= saved_status_word_r;
        IDX_FAST_VEC:     reg_rdata_out <= fast_vector_r;
        IDX_FLOAT_STATUS: reg_rdata_out <= float_status_word_r;
        default: begin
          if (reg_addr_in == 5'h00) begin
            reg_rdata_out <= active_sp;
          end else if (reg_addr_in <= IDX_GPR_LAST) begin
            reg_rdata_out <= gpr_r[reg_addr_in[3:0]];
          end else begin
            reg_rdata_out <= RST_ZERO;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      stack_pointer_out   <= RST_ZERO;
      program_counter_out <= RST_ZERO;
      status_word_out     <= RST_ZERO;
      exception_base_out  <= RST_ZERO;
      interrupt_base_out  <= RST_ZERO;
    end else begin
      stack_pointer_out   <= active_sp;
      program_counter_out <= program_counter_r;
      status_word_out     <= status_word_r;
      exception_base_out  <= exception_base_r;
      interrupt_base_out  <= interrupt_base_r;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_FAST_PC_SAVE: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    fast_irq_accept_in |=> saved_counter_r == $past(program_counter_r))
    else $error("saved counter missed program counter");
  AST_FAST_PSW_SAVE: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    fast_irq_accept_in |=> saved_status_word_r == $past(status_word_r))
    else $error("saved status missed status word");
  AST_FAST_BRANCH: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    fast_irq_accept_in |=> program_counter_r == $past(fast_vector_r))
    else $error("fast interrupt did not branch to fast vector");
  AST_FAST_RETURN: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (fast_irq_return_in && !fast_irq_accept_in) |=>
      program_counter_r == $past(saved_counter_r) &&
      status_word_r == $past(saved_status_word_r))
    else $error("fast return did not restore");
  AST_STICKY_HOLD: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !(|sticky_wr) |=>
      (float_status_word_r[FP_STICKY_LSB +: FP_EXC_NUM] &
       $past(float_status_word_r[FP_STICKY_LSB +: FP_EXC_NUM])) ==
       $past(float_status_word_r[FP_STICKY_LSB +: FP_EXC_NUM]))
    else $error("sticky flag dropped without software clear");
  AST_STICKY_SET: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    |fp_exc_in |=> (float_status_word_r[FP_STICKY_LSB +: FP_EXC_NUM] &
      $past(fp_exc_in)) == $past(fp_exc_in))
    else $error("sticky flag not set by exception");
  AST_CAUSE_SET: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    |fp_exc_in |=> float_status_word_r[FP_CAUSE_LSB +: FP_EXC_NUM] ==
      ($past(fp_exc_in) & $past(exception_enable_bits)))
    else $error("cause flags wrong");
  AST_SP_SELECT: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (reg_rd_in && reg_addr_in == 5'h00) |=>
      reg_rdata_out == ($past(user_sel) ? $past(user_stack_pointer_r)
                                        : $past(interrupt_stack_pointer_r)))
    else $error("register zero not the selected stack pointer");
  AST_BASE_WRITE: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (reg_wr_in && reg_addr_in == IDX_EXC_BASE) |=> ##1
      exception_base_out == $past(reg_wdata_in, 2))
    else $error("exception base not updated");
  AST_PC_LOAD: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (pc_load_in && !fast_irq_accept_in && !fast_irq_return_in) |=>
      program_counter_r == $past(pc_next_in))
    else $error("program counter not loaded");

endmodule : cpu_register_set

// >>> pkg/cpu_regs_pkg.sv
// package for the core register set: widths, register map, field layouts, resets
// assumes a single 100 MHz core clock and a plain register port
package cpu_regs_pkg;

  localparam int unsigned DATA_W  = 32;
  localparam int unsigned GPR_NUM = 16;
  localparam int unsigned ADDR_W  = 5;

  // ---------------------------------------------------------------
  // register map (word index on the register port)
  // ---------------------------------------------------------------
  // indices 0..15 are the general-purpose registers
  localparam logic [4:0] IDX_GPR_LAST     = 5'h0f;
  localparam logic [4:0] IDX_INT_SP       = 5'h10;
  localparam logic [4:0] IDX_USER_SP      = 5'h11;
  localparam logic [4:0] IDX_EXC_BASE     = 5'h12;
  localparam logic [4:0] IDX_INT_BASE     = 5'h13;
  localparam logic [4:0] IDX_PROG_CNT     = 5'h14;
  localparam logic [4:0] IDX_STATUS       = 5'h15;
  localparam logic [4:0] IDX_SAVED_CNT    = 5'h16;
  localparam logic [4:0] IDX_SAVED_STATUS = 5'h17;
  localparam logic [4:0] IDX_FAST_VEC     = 5'h18;
  localparam logic [4:0] IDX_FLOAT_STATUS = 5'h19;

  // ---------------------------------------------------------------
  // fields
  // ---------------------------------------------------------------
  // status word: stack select bit
  localparam int unsigned STATUS_STACK_SEL_BIT = 17;
  // float status word: five exception kinds each for cause, enable, sticky
  localparam int unsigned FP_EXC_NUM   = 5;
  localparam int unsigned FP_CAUSE_LSB = 2;
  localparam int unsigned FP_EN_LSB    = 10;
  localparam int unsigned FP_STICKY_LSB = 26;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] RST_ZERO   = 32'h0000_0000;
  localparam logic [31:0] RST_FP_STATUS = 32'h0000_0100;

endpackage : cpu_regs_pkg

// >>> testbench/cpu_register_set_fast_irq_tb.sv
// self-checking bench for the core register set: register port, stack select,
// fast interrupt save/restore and float flags
// assumes cpu_regs_pkg is compiled first; reads are checked from a queue of notes
`timescale 1ns/1ps

module cpu_register_set_fast_irq_tb;
  import cpu_regs_pkg::*;

  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic              core_clk_in;
  logic              rst_n_in;
  logic [4:0]        reg_addr_in;
  logic [31:0]       reg_wdata_in;
  logic              reg_wr_in;
  logic              reg_rd_in;
  logic [31:0]       reg_rdata_out;
  logic              pc_load_in;
  logic [31:0]       pc_next_in;
  logic              fast_irq_accept_in;
  logic              fast_irq_return_in;
  logic              sp_update_in;
  logic [31:0]       sp_next_in;
  logic [4:0]        fp_exc_in;
  logic [31:0]       stack_pointer_out;
  logic [31:0]       program_counter_out;
  logic [31:0]       status_word_out;
  logic [31:0]       exception_base_out;
  logic [31:0]       interrupt_base_out;
  // next-cycle requests, applied together at one edge so no input is assigned twice
  logic              n_wr, n_rd, n_pcl, n_fa, n_fr, n_spu;
  logic [4:0]        n_addr, n_exc;
  logic [31:0]       n_wd, n_pc, n_sp;
  logic [31:0]       exp_q[$];
  logic [31:0]       msk_q[$];
  logic              rd_seen;
  int                n_errors, n_tests, seed, j;
  logic [31:0]       va, vb, vp, vv, vs;
  logic [4:0]        en, stk;
  localparam logic [31:0] FMASK = 32'h7c00_7c7c;

  cpu_register_set dut_u (
    .core_clk_in        (core_clk_in),
    .rst_n_in           (rst_n_in),
    .reg_addr_in        (reg_addr_in),
    .reg_wdata_in       (reg_wdata_in),
    .reg_wr_in          (reg_wr_in),
    .reg_rd_in          (reg_rd_in),
    .reg_rdata_out      (reg_rdata_out),
    .pc_load_in         (pc_load_in),
    .pc_next_in         (pc_next_in),
    .fast_irq_accept_in (fast_irq_accept_in),
    .fast_irq_return_in (fast_irq_return_in),
    .sp_update_in       (sp_update_in),
    .sp_next_in         (sp_next_in),
    .fp_exc_in          (fp_exc_in),
    .stack_pointer_out  (stack_pointer_out),
    .program_counter_out(program_counter_out),
    .status_word_out    (status_word_out),
    .exception_base_out (exception_base_out),
    .interrupt_base_out (interrupt_base_out)
  );

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task tick();
    @(posedge core_clk_in);
    reg_wr_in          <= n_wr;
    reg_rd_in          <= n_rd;
    reg_addr_in        <= n_addr;
    reg_wdata_in       <= n_wd;
    pc_load_in         <= n_pcl;
    pc_next_in         <= n_pc;
    fast_irq_accept_in <= n_fa;
    fast_irq_return_in <= n_fr;
    sp_update_in       <= n_spu;
    sp_next_in         <= n_sp;
    fp_exc_in          <= n_exc;
    {n_wr, n_rd, n_pcl, n_fa, n_fr, n_spu, n_exc} = '0;
  endtask : tick

  task wr(input logic [4:0] a, input logic [31:0] d);
    n_wr = 1'b1;
    n_addr = a;
    n_wd = d;
    tick();
  endtask : wr

  task rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffff_ffff);
    n_rd = 1'b1;
    n_addr = a;
    exp_q.push_back(e);
    msk_q.push_back(m);
    tick();
  endtask : rd

  task results();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  // ---------------------------------------------------------------
  // clock, read-data monitor, watchdog
  // ---------------------------------------------------------------
  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  always @(posedge core_clk_in) rd_seen <= reg_rd_in;

  // read data appears in the cycle after the strobe and holds until the next read, so it is sampled mid-cycle
  always @(negedge core_clk_in) begin
    if (rd_seen === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_errors++;
        $display("wrong value read queue expected note seen none");
      end else begin
        check("read data", reg_rdata_out & msk_q.pop_front(), exp_q.pop_front());
      end
    end
  end

  initial begin
    repeat (20000) @(posedge core_clk_in);
    n_errors++;
    results();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 40981;
    {n_wr, n_rd, n_pcl, n_fa, n_fr, n_spu, n_exc, n_addr} = '0;
    {n_wd, n_pc, n_sp} = '0;
    {reg_wr_in, reg_rd_in, pc_load_in, fast_irq_accept_in, fast_irq_return_in} = '0;
    {sp_update_in, fp_exc_in, reg_addr_in, reg_wdata_in, pc_next_in, sp_next_in} = '0;
    rst_n_in = 1'b0;
    repeat (20) @(posedge core_clk_in);
    #1;
    check("views in reset", stack_pointer_out | program_counter_out | status_word_out
          | exception_base_out | interrupt_base_out, 32'h0000_0000);
    rst_n_in <= 1'b0;
    @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    // reset values of every index, unmapped ones included
    for (j = 0; j < 32; j++) begin
      rd(j[4:0], (j[4:0] == IDX_FLOAT_STATUS) ? RST_FP_STATUS : RST_ZERO);
    end
    // general registers back to back, plus an ignored write to an unmapped index
    for (j = 1; j < 16; j++) begin
      va = $random(seed);
      wr(j[4:0], va);
      rd(j[4:0], va);
    end
    wr(5'h1c, $random(seed));
    rd(5'h1c, 32'h0000_0000);
    // stack pointer: index zero follows the select bit
    va = $random(seed);
    vb = $random(seed);
    wr(5'h00, va);
    rd(IDX_INT_SP, va);
    rd(IDX_USER_SP, 32'h0000_0000);
    vs = 32'h0000_0001 << STATUS_STACK_SEL_BIT;
    wr(IDX_STATUS, vs);
    rd(5'h00, 32'h0000_0000);
    n_spu = 1'b1;
    n_sp = vb;
    tick();
    rd(IDX_USER_SP, vb);
    rd(IDX_INT_SP, va);
    rd(5'h00, vb);
    #1;
    check("stack pointer view", stack_pointer_out, vb);
    // table bases, views two edges after the write
    va = $random(seed);
    vb = $random(seed);
    wr(IDX_EXC_BASE, va);
    wr(IDX_INT_BASE, vb);
    tick();
    tick();
    #1;
    check("exception base view", exception_base_out, va);
    check("interrupt base view", interrupt_base_out, vb);
    // program counter load
    vp = $random(seed);
    n_pcl = 1'b1;
    n_pc = vp;
    tick();
    rd(IDX_PROG_CNT, vp);
    // the view trails the register by one edge
    tick();
    #1;
    check("program counter view", program_counter_out, vp);
    // fast interrupt; a saved-counter write in the same cycle must lose
    vv = $random(seed);
    wr(IDX_FAST_VEC, vv);
    n_fa = 1'b1;
    n_wr = 1'b1;
    n_addr = IDX_SAVED_CNT;
    n_wd = ~vp;
    tick();
    rd(IDX_SAVED_CNT, vp);
    rd(IDX_SAVED_STATUS, vs);
    rd(IDX_PROG_CNT, vv);
    #1;
    check("program counter after accept", program_counter_out, vv);
    wr(IDX_STATUS, 32'h0000_0000);
    n_pcl = 1'b1;
    n_pc = ~vv;
    tick();
    n_fr = 1'b1;
    tick();
    rd(IDX_PROG_CNT, vp);
    rd(IDX_STATUS, vs);
    #1;
    check("status word view", status_word_out, vs);
    // float flags: each kind in turn with a mixed enable pattern
    en = 5'h15;
    stk = 5'h00;
    wr(IDX_FLOAT_STATUS, {27'h000_0000, en} << FP_EN_LSB);
    for (j = 0; j < FP_EXC_NUM; j++) begin
      n_exc = 5'h01 << j;
      stk = stk | n_exc;
      // a read in the event's own cycle sees the word before it, so read one cycle later
      tick();
      rd(IDX_FLOAT_STATUS, ({27'h0, stk} << FP_STICKY_LSB) | ({27'h0, en} << FP_EN_LSB)
         | ({27'h0, (5'h01 << j) & en} << FP_CAUSE_LSB), FMASK);
    end
    // software clear racing a new event: the new event keeps its sticky bit
    n_exc = 5'h02;
    wr(IDX_FLOAT_STATUS, {27'h000_0000, en} << FP_EN_LSB);
    rd(IDX_FLOAT_STATUS, 32'h0800_0000, 32'h7c00_0000);
    wr(IDX_FLOAT_STATUS, 32'h0000_0000);
    rd(IDX_FLOAT_STATUS, 32'h0000_0000, FMASK);
    tick();
    tick();
    check("notes left", exp_q.size(), 32'h0000_0000);
    results();
  end

endmodule : cpu_register_set_fast_irq_tb
